// ==== logic/wsac_pkg.sv ====
// Purpose: constants for the watchdog standby/always-on control block
// Assumes: 32-bit register port, byte offsets, word aligned
// Notes:   watchdog domain modelled as a tick enable on clk
package wsac_pkg;
    localparam int         ADDR_W         = 8;
    localparam int         DATA_W         = 32;
    localparam int         PER_W          = 4;
    localparam int         KEY_W          = 8;
    localparam logic [7:0] OFS_CTRL_A     = 8'h00;
    localparam logic [7:0] OFS_CONFIG     = 8'h04;
    localparam logic [7:0] OFS_EW_CTRL    = 8'h08;
    localparam logic [7:0] OFS_INTEN_CLR  = 8'h0C;
    localparam logic [7:0] OFS_INTEN_SET  = 8'h10;
    localparam logic [7:0] OFS_INT_FLAG   = 8'h14;
    localparam logic [7:0] OFS_SYNC_BUSY  = 8'h18;
    localparam logic [7:0] OFS_CLEAR      = 8'h1C;
    localparam logic [7:0] OFS_STATUS     = 8'h20;
    // control_a_reg bit positions
    localparam int         BIT_ENABLE     = 1;
    localparam int         BIT_WEN        = 2;
    localparam int         BIT_RUN_STDBY  = 6;
    localparam int         BIT_ALWAYS_ON  = 7;
    // config field positions
    localparam int         POS_PER        = 0;
    localparam int         POS_WINDOW     = 4;
    // interrupt bits
    localparam int         INT_EW         = 0;
    localparam int         INT_SYNC       = 1;
    localparam int         INT_W          = 2;
    // sync busy bits
    localparam int         SB_ENABLE      = 1;
    localparam int         SB_WEN         = 2;
    localparam int         SB_RUN_STDBY   = 3;
    localparam int         SB_ALWAYS_ON   = 4;
    localparam int         SB_CLEAR       = 5;
    // reset values
    localparam logic [3:0] RST_PER        = 4'hB;
    localparam logic [3:0] RST_WINDOW     = 4'hB;
    localparam logic [3:0] RST_EW_OFFSET  = 4'hB;
    // watchdog ticks a write needs to land
    localparam int         SYNC_TICKS     = 2;
    localparam int         SYNC_CNT_W     = 2;
    // clear key value is arbitrary
    localparam logic [7:0] CLEAR_KEY      = 8'h5A;
endpackage

// ==== logic/wsac_sync_stage.sv ====
// Purpose: carries one written field into the watchdog tick domain
// Assumes: tick is a one-cycle enable marking watchdog clock edges
// Notes:   a newer write while busy replaces the pending value
`timescale 1ns/100ps
module wsac_sync_stage #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         tick,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic              busy,
    output logic              done
);
    import wsac_pkg::*;

    logic [W-1:0]          pend;
    logic [SYNC_CNT_W-1:0] cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= '0;
            cnt  <= '0;
            busy <= 1'b0;
            q    <= '0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (load) begin
                pend <= d;
                cnt  <= '0;
                busy <= 1'b1;
            end else if (busy && tick) begin
                if (cnt == SYNC_CNT_W'(SYNC_TICKS - 1)) begin
                    q    <= pend;
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule

// ==== logic/wsac_ctrl.sv ====
// Purpose: watchdog control: standby run, write sync, always-on lock
// Assumes: rst_n is the power-on reset; inputs synchronous to clk
// Notes:   counter itself lives outside; this block steers it
`timescale 1ns/100ps
module wsac_ctrl (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    input  wire logic [wsac_pkg::ADDR_W-1:0]   addr,
    input  wire logic [wsac_pkg::DATA_W-1:0]   wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [wsac_pkg::DATA_W-1:0]   rdata,
    input  wire logic                          wd_tick,
    input  wire logic                          standby,
    input  wire logic                          ew_event,
    output logic                               wd_run,
    output logic                               wd_window_en,
    output logic      [wsac_pkg::PER_W-1:0]    timeout_length,
    output logic      [wsac_pkg::PER_W-1:0]    window_length,
    output logic      [wsac_pkg::PER_W-1:0]    early_warning_offset,
    output logic                               wd_clear,
    output logic                               irq
);
    import wsac_pkg::*;

    // bus-side shadows of control_a_reg
    logic               enable_b;
    logic               wen_b;
    logic               run_in_standby_b;
    logic               always_on_lock_b;
    // watchdog-side values
    logic               enable_w;
    logic               wen_w;
    logic               run_in_standby_w;
    logic               always_on_lock_w;
    logic [KEY_W-1:0]   clear_w;
    logic [4:0]         busy;
    logic [4:0]         done;
    logic [INT_W-1:0]   int_flag;
    logic               ew_flag;
    logic               sync_flag;
    logic [INT_W-1:0]   int_en;
    logic               clear_done;

    // exact match only; partial-width accesses are not decoded
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    wire wr_ctrl  = wr && hit(addr, OFS_CTRL_A);
    wire wr_cfg   = wr && hit(addr, OFS_CONFIG);
    wire wr_ew    = wr && hit(addr, OFS_EW_CTRL);
    wire wr_iclr  = wr && hit(addr, OFS_INTEN_CLR);
    wire wr_iset  = wr && hit(addr, OFS_INTEN_SET);
    wire wr_flag  = wr && hit(addr, OFS_INT_FLAG);
    wire wr_clear = wr && hit(addr, OFS_CLEAR);
    // lock counts from the write onward, not only once it has crossed
    wire locked   = always_on_lock_b;

    // bus-side shadows so reads return the written value at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_b <= 1'b0;
        end else if (ce && wr_ctrl) begin
            enable_b <= wdata[BIT_ENABLE];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wen_b <= 1'b0;
        end else if (ce && wr_ctrl) begin
            wen_b <= wdata[BIT_WEN];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_in_standby_b <= 1'b0;
        end else if (ce && wr_ctrl) begin
            run_in_standby_b <= wdata[BIT_RUN_STDBY];
        end
    end

    // only a power-on reset drops the lock; a zero write is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            always_on_lock_b <= 1'b0;
        end else if (ce && wr_ctrl && wdata[BIT_ALWAYS_ON]) begin
            always_on_lock_b <= 1'b1;
        end
    end

    // each write-synchronized field crosses on its own stage
    // any control write reloads all three field stages at once
    wsac_sync_stage #(.W(1)) u_sync_enable (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .tick  (wd_tick),
        .load  (wr_ctrl),
        .d     (wdata[BIT_ENABLE]),
        .q     (enable_w),
        .busy  (busy[0]),
        .done  (done[0])
    );

    wsac_sync_stage #(.W(1)) u_sync_wen (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .tick  (wd_tick),
        .load  (wr_ctrl),
        .d     (wdata[BIT_WEN]),
        .q     (wen_w),
        .busy  (busy[1]),
        .done  (done[1])
    );

    wsac_sync_stage #(.W(1)) u_sync_stdby (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .tick  (wd_tick),
        .load  (wr_ctrl),
        .d     (wdata[BIT_RUN_STDBY]),
        .q     (run_in_standby_w),
        .busy  (busy[2]),
        .done  (done[2])
    );

    // a zero write never reaches the lock stage
    wsac_sync_stage #(.W(1)) u_sync_aon (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .tick  (wd_tick),
        .load  (wr_ctrl && wdata[BIT_ALWAYS_ON]),
        .d     (1'b1),
        .q     (always_on_lock_w),
        .busy  (busy[3]),
        .done  (done[3])
    );

    wsac_sync_stage #(.W(KEY_W)) u_sync_clear (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .tick  (wd_tick),
        .load  (wr_clear),
        .d     (wdata[KEY_W-1:0]),
        .q     (clear_w),
        .busy  (busy[4]),
        .done  (clear_done)
    );

    assign done[4] = clear_done;

    // timing configuration, frozen while locked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_length <= RST_PER;
        end else if (ce && wr_cfg && !locked) begin
            timeout_length <= wdata[POS_PER +: PER_W];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_length <= RST_WINDOW;
        end else if (ce && wr_cfg && !locked) begin
            window_length <= wdata[POS_WINDOW +: PER_W];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            early_warning_offset <= RST_EW_OFFSET;
        end else if (ce && wr_ew && !locked) begin
            early_warning_offset <= wdata[PER_W-1:0];
        end
    end

    // interrupt enables ignore the lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_en <= '0;
        end else if (ce) begin
            if (wr_iset) begin
                int_en <= int_en | wdata[INT_W-1:0];
            end else if (wr_iclr) begin
                int_en <= int_en & ~wdata[INT_W-1:0];
            end
        end
    end

    // sticky flags; a new event beats a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ew_flag <= 1'b0;
        end else if (ce) begin
            if (ew_event) begin
                ew_flag <= 1'b1;
            end else if (wr_flag && wdata[INT_EW]) begin
                ew_flag <= 1'b0;
            end
        end
    end

    // any landed write raises it, so software need not poll busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_flag <= 1'b0;
        end else if (ce) begin
            if (|done) begin
                sync_flag <= 1'b1;
            end else if (wr_flag && wdata[INT_SYNC]) begin
                sync_flag <= 1'b0;
            end
        end
    end

    assign int_flag = {sync_flag, ew_flag};

    assign irq = |(int_flag & int_en);

    // run decision in the watchdog domain
    // configuration is kept; only counting halts in standby, and not when run_in_standby_w is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_run <= 1'b0;
        end else if (ce) begin
            wd_run <= (enable_w || always_on_lock_w)
                   && (!standby || run_in_standby_w);
        end
    end

    // window off under lock gives plain always-on mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_window_en <= 1'b0;
        end else if (ce) begin
            wd_window_en <= wen_w;
        end
    end

    // key judged only once the write has crossed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_clear <= 1'b0;
        end else if (ce) begin
            wd_clear <= clear_done && (clear_w == CLEAR_KEY);
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (rd) begin
                case (addr)
                    OFS_CTRL_A: begin
                        rdata[BIT_ENABLE]    <= enable_b;
                        rdata[BIT_WEN]       <= wen_b;
                        rdata[BIT_RUN_STDBY] <= run_in_standby_b;
                        rdata[BIT_ALWAYS_ON] <= always_on_lock_b;
                    end
                    OFS_CONFIG: begin
                        rdata[POS_PER +: PER_W]    <= timeout_length;
                        rdata[POS_WINDOW +: PER_W] <= window_length;
                    end
                    OFS_EW_CTRL: begin
                        rdata[PER_W-1:0] <= early_warning_offset;
                    end
                    OFS_INTEN_CLR, OFS_INTEN_SET: begin
                        rdata[INT_W-1:0] <= int_en;
                    end
                    OFS_INT_FLAG: begin
                        rdata[INT_W-1:0] <= int_flag;
                    end
                    OFS_SYNC_BUSY: begin
                        rdata[SB_ENABLE]    <= busy[0];
                        rdata[SB_WEN]       <= busy[1];
                        rdata[SB_RUN_STDBY] <= busy[2];
                        rdata[SB_ALWAYS_ON] <= busy[3];
                        rdata[SB_CLEAR]     <= busy[4];
                    end
                    // synced values, so software sees what the counter obeys
                    OFS_STATUS: begin
                        rdata[0] <= wd_run;
                        rdata[1] <= always_on_lock_w;
                        rdata[2] <= wd_window_en;
                    end
                    default: begin
                        rdata <= '0;
                    end
                endcase
            end
        end
    end
endmodule

// ==== tb/wsac_ctrl_sva.sv ====
// Purpose: port-level checks for the watchdog control block
// Assumes: ce held high whenever these relations matter
// Notes:   bound into every wsac_ctrl instance
`timescale 1ns/100ps
module wsac_ctrl_sva (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic                        ce,
    input wire logic [wsac_pkg::ADDR_W-1:0] addr,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [wsac_pkg::DATA_W-1:0] rdata,
    input wire logic                        wd_tick,
    input wire logic                        standby,
    input wire logic                        wd_run,
    input wire logic                        wd_window_en,
    input wire logic [wsac_pkg::PER_W-1:0]  timeout_length,
    input wire logic [wsac_pkg::PER_W-1:0]  window_length,
    input wire logic [wsac_pkg::PER_W-1:0]  early_warning_offset,
    input wire logic                        wd_clear
);
    import wsac_pkg::*;
    logic cfg_wr;
    logic ew_wr;
    assign cfg_wr = wr && ce && addr == OFS_CONFIG;
    assign ew_wr  = wr && ce && addr == OFS_EW_CTRL;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // period and window move only on a config write
    cfg_hold_a: assert property (!$past(cfg_wr) |-> $stable(timeout_length))
        else $error("period changed without config write");
    win_hold_a: assert property (!$past(cfg_wr) |-> $stable(window_length))
        else $error("window changed without config write");
    ew_hold_a: assert property (!$past(ew_wr) |-> $stable(early_warning_offset))
        else $error("offset changed without warning write");
    run_cause_a: assert property ($changed(wd_run) |->
        $past(standby) != $past(standby, 2) || $past(wd_tick) || $past(wd_tick, 2))
        else $error("run level moved with no cause");
    wen_cause_a: assert property ($changed(wd_window_en) |->
        $past(wd_tick) || $past(wd_tick, 2)) else $error("window enable moved off tick");
    clr_pulse_a: assert property (wd_clear |=> !wd_clear)
        else $error("clear pulse too long");
    clr_cause_a: assert property (wd_clear |->
        $past(wd_tick, 2) || $past(wd_tick, 3)) else $error("clear pulse off tick");
    rd_idle_a: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data outside read slot");
    cover property (wd_clear);
    cover property (standby && wd_run);
    cover property ($rose(wd_window_en));
endmodule

bind wsac_ctrl wsac_ctrl_sva chk (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr(wr),
    .rd(rd), .rdata(rdata), .wd_tick(wd_tick), .standby(standby), .wd_run(wd_run),
    .wd_window_en(wd_window_en), .timeout_length(timeout_length),
    .window_length(window_length), .early_warning_offset(early_warning_offset),
    .wd_clear(wd_clear));

// ==== tb/watchdog_standby_always_on_lock_ctrl_tb.sv ====
// Purpose: register-level tests of the watchdog control block
// Assumes: watchdog edges given as wd_tick pulses on clk
// Notes:   ce dropped once around a write to check the freeze
`timescale 1ns/100ps
module watchdog_standby_always_on_lock_ctrl_tb;
    import wsac_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, wd_tick = 0, standby = 0, ew_event = 0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic wd_run, wd_window_en, wd_clear, irq;
    logic [3:0] tl, wl, eo;
    int fail_count = 0, num_checks = 0;
    wsac_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .wd_tick(wd_tick), .standby(standby), .ew_event(ew_event),
        .wd_run(wd_run), .wd_window_en(wd_window_en), .timeout_length(tl),
        .window_length(wl), .early_warning_offset(eo), .wd_clear(wd_clear), .irq(irq));
    initial forever #2 clk = ~clk;
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk) wr <= 1; addr <= a; wdata <= d;
        @(posedge clk) wr <= 0;
    endtask
    task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
        @(posedge clk) rd <= 1; addr <= a;
        @(posedge clk) rd <= 0;
        @(negedge clk) chk("rdata", exp, rdata);
    endtask
    // two watchdog edges land a write, then let run level settle
    task automatic ticks();
        repeat (2) begin
            @(posedge clk) wd_tick <= 1;
            @(posedge clk) wd_tick <= 0;
        end
        repeat (3) @(posedge clk);
    endtask
    // two watchdog edges land the key; the pulse stands two cycles later
    task automatic clr_seen(logic exp);
        logic seen;
        seen = 0;
        repeat (2) begin
            @(posedge clk) wd_tick <= 1;
            @(posedge clk) wd_tick <= 0;
        end
        repeat (4) begin
            @(negedge clk) seen |= wd_clear;
        end
        chk("wd_clear", 32'(exp), 32'(seen));
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(4 * 5000);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        chk("period", 32'h0000_000B, 32'(tl));
        wr_reg(OFS_CONFIG, 32'h0000_0037);
        wr_reg(OFS_EW_CTRL, 32'h0000_0005);
        wr_reg(OFS_CTRL_A, 32'h0000_0002);
        rd_chk(OFS_SYNC_BUSY, 32'h0000_000E);
        ticks();
        rd_chk(OFS_SYNC_BUSY, 32'h0000_0000);
        chk("run", 1, 32'(wd_run));
        @(posedge clk) standby <= 1;
        repeat (3) @(posedge clk);
        chk("run", 0, 32'(wd_run));
        chk("period", 32'h0000_0037, 32'({wl, tl}));
        wr_reg(OFS_CTRL_A, 32'h0000_0042);
        ticks();
        chk("run", 1, 32'(wd_run));
        @(posedge clk) standby <= 0;
        wr_reg(OFS_CTRL_A, 32'h0000_0080);
        ticks();
        chk("run", 1, 32'(wd_run));
        wr_reg(OFS_CONFIG, 32'h0000_0000);
        wr_reg(OFS_EW_CTRL, 32'h0000_0000);
        wr_reg(OFS_CTRL_A, 32'h0000_0004);
        rd_chk(OFS_CTRL_A, 32'h0000_0084);
        ticks();
        chk("window", 1, 32'(wd_window_en));
        chk("cfg", 32'h0000_0375, 32'({wl, tl, eo}));
        rd_chk(OFS_STATUS, 32'h0000_0007);
        wr_reg(OFS_INT_FLAG, 32'h0000_0007);
        wr_reg(OFS_INTEN_SET, 32'h0000_0001);
        rd_chk(OFS_INTEN_SET, 32'h0000_0001);
        @(posedge clk) ew_event <= 1;
        @(posedge clk) ew_event <= 0;
        @(negedge clk) chk("irq", 1, 32'(irq));
        rd_chk(OFS_INT_FLAG, 32'h0000_0001);
        wr_reg(OFS_INT_FLAG, 32'h0000_0001);
        wr_reg(OFS_INTEN_CLR, 32'h0000_0001);
        rd_chk(OFS_INTEN_CLR, 32'h0000_0000);
        @(posedge clk) ce <= 0;
        wr_reg(OFS_INTEN_SET, 32'h0000_0001);
        @(posedge clk) ce <= 1;
        rd_chk(OFS_INTEN_SET, 32'h0000_0000);
        @(posedge clk) ew_event <= 1;
        @(posedge clk) ew_event <= 0;
        @(negedge clk) chk("irq", 0, 32'(irq));
        rd_chk(8'h40, 32'h0000_0000);
        wr_reg(OFS_CLEAR, 32'(CLEAR_KEY));
        clr_seen(1);
        wr_reg(OFS_CLEAR, 32'h0000_0011);
        clr_seen(0);
        summarize();
    end
endmodule
